// File: hw/adcsc_pkg.sv
// Purpose: shared constants and types for the converter sequencer control
// Assumes: register index i sits at byte address i on the plain register port
// Notes: phase counts are in converter clock cycles
package adcsc_pkg;

  localparam int ADCSC_ADDR_W = 2;
  localparam logic [1:0] ADCSC_CTRL_OFF = 2'h0;
  localparam logic [1:0] ADCSC_RESULT_OFF = 2'h1;
  localparam logic [1:0] ADCSC_STATUS_OFF = 2'h2;

  localparam logic [7:0] ADCSC_CTRL_RST = 8'h00;
  localparam logic [7:0] ADCSC_RESULT_RST = 8'h00;

  localparam int ADCSC_CHAN_HI = 7;
  localparam int ADCSC_CHAN_LO = 5;
  localparam int ADCSC_DIFF_BIT = 4;
  localparam int ADCSC_CONT_BIT = 3;
  localparam int ADCSC_PRE_HI = 2;
  localparam int ADCSC_PRE_LO = 0;
  localparam int ADCSC_BUSY_BIT = 0;
  localparam int ADCSC_POWER_BIT = 1;

  localparam logic [2:0] ADCSC_PRE_OFF = 3'h0;
  localparam logic [4:0] ADCSC_DIV_1 = 5'h01;
  localparam logic [4:0] ADCSC_DIV_2 = 5'h02;
  localparam logic [4:0] ADCSC_DIV_4 = 5'h04;
  localparam logic [4:0] ADCSC_DIV_6 = 5'h06;
  localparam logic [4:0] ADCSC_DIV_12 = 5'h0c;
  localparam logic [4:0] ADCSC_DIV_8 = 5'h08;
  localparam logic [4:0] ADCSC_DIV_16 = 5'h10;

  localparam logic [3:0] ADCSC_SAMPLE_CYC = 4'h2;
  localparam logic [3:0] ADCSC_CONVERT_CYC = 4'h8;
  localparam logic [3:0] ADCSC_LOAD_CYC = 4'h1;
  localparam logic [3:0] ADCSC_DESEL_CYC = 4'h1;

  typedef enum logic [2:0] {
    ADCSC_ST_OFF,
    ADCSC_ST_ARM,
    ADCSC_ST_SAMPLE,
    ADCSC_ST_CONVERT,
    ADCSC_ST_LOAD,
    ADCSC_ST_DESEL
  } adcsc_state_e;

  typedef struct packed {
    logic power_up;
    logic sample;
    logic select;
    logic load_clk;
    logic diff;
    logic [2:0] vin_pos;
    logic [2:0] vin_neg;
  } adcsc_core_s;

endpackage

// File: hw/adcsc_top.sv
// Purpose: control of an 8-channel successive approximation converter core
// Assumes: ref_clk is the core oscillator input clock; core_done and core_data
//   come from the converter core on ref_clk; halt_idle is on ref_clk too
// Notes: the converter clock is a one-cycle tick that marks its falling edge
//
// What this block does
// RQ1 - control bits 7..5 pick the positive input; single-ended uses code directly
// RQ2 - differential: even code 2k is 2k vs 2k+1, odd code reverses the pair
// RQ3 - bits 4..3 pick single-ended/differential and single/continuous
// RQ4 - bits 2..0: 000 stops clock, else divide by 1,2,4,6,12,8,16
// RQ5 - accepted control write starts a conversion unless prescaler is zero
// RQ6 - conversion begins and converter powers up in the write cycle
// RQ7 - sample high two converter cycles from first falling edge after write
// RQ8 - converter select rises at the middle of the sample period
// RQ9 - single modes: conversion complete powers the converter down
// RQ10 - continuous modes: deselect one converter cycle, then sample again
// RQ11 - result register loads only after load clock falls, never while high
// RQ12 - while busy, writes to all control bits except busy are ignored
// RQ13 - busy clears on completion or by software before setting changes
// RQ14 - after a stop, one control write sets new values and starts
// RQ15 - converter clock rate is oscillator clock over the prescaler value
// RQ16 - software keeps converter clock between 100 kHz and 1.67 MHz
// RQ17 - conversion is reset, two sample, eight convert, one load cycles
// RQ18 - the result register is read-only; writes to it do nothing
// RQ19 - halt or idle powers down; running conversion restarts on leaving
// RQ20 - reset clears control and powers the converter down
// RQ21 - busy sets on start; single clears at result load, continuous stays
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ns
module adcsc_top (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [adcsc_pkg::ADCSC_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic halt_idle,
  input wire logic core_done,
  input wire logic [7:0] core_data,
  output adcsc_pkg::adcsc_core_s core_ctl,
  output logic conv_clk_tick
);
  import adcsc_pkg::*;

  logic [7:0] adc_control_reg;
  logic [7:0] adc_result_reg;
  logic conversion_busy_flag;
  logic restart_reg;
  logic [7:0] data_hold_reg;
  logic done_seen_reg;
  logic [4:0] div_cnt_reg;
  logic tick_reg;
  logic [3:0] phase_cnt_reg;
  adcsc_state_e state_reg;
  adcsc_core_s core_reg;
  logic power_up_reg;
  logic sample_reg;
  logic select_reg;
  logic load_clk_reg;
  logic diff_reg;
  logic [2:0] vin_pos_reg;
  logic [2:0] vin_neg_reg;

  logic ctrl_wr;
  logic start;
  logic stop_sw;
  logic [4:0] div_val;
  logic [2:0] chan;
  logic phase_last;
  logic complete;
  logic run_ok;
  logic single_done;
  logic power_next;
  logic sample_next;
  logic select_next;
  logic load_next;

  // writes are only taken while idle, so a busy block keeps its settings
  assign ctrl_wr = reg_wr && reg_addr == ADCSC_CTRL_OFF && !conversion_busy_flag; // RQ12
  assign start = ctrl_wr && reg_wdata[ADCSC_PRE_HI:ADCSC_PRE_LO] != ADCSC_PRE_OFF; // RQ5 RQ14
  assign stop_sw = reg_wr && reg_addr == ADCSC_STATUS_OFF && !reg_wdata[ADCSC_BUSY_BIT]; // RQ13
  assign chan = adc_control_reg[ADCSC_CHAN_HI:ADCSC_CHAN_LO];
  assign phase_last = tick_reg && phase_cnt_reg == 4'h1;
  assign complete = state_reg == ADCSC_ST_LOAD && phase_last && done_seen_reg;
  // halt, idle or a software stop silence every core phase at once
  assign run_ok = !halt_idle && !stop_sw;
  assign single_done = complete && !adc_control_reg[ADCSC_CONT_BIT];

  always_comb begin
    unique case (adc_control_reg[ADCSC_PRE_HI:ADCSC_PRE_LO]) // RQ4
      3'h1: div_val = ADCSC_DIV_1;
      3'h2: div_val = ADCSC_DIV_2;
      3'h3: div_val = ADCSC_DIV_4;
      3'h4: div_val = ADCSC_DIV_6;
      3'h5: div_val = ADCSC_DIV_12;
      3'h6: div_val = ADCSC_DIV_8;
      3'h7: div_val = ADCSC_DIV_16;
      default: div_val = 5'h00;
    endcase
  end

  // control register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      adc_control_reg <= ADCSC_CTRL_RST; // RQ20
    end else if (ctrl_wr) begin
      adc_control_reg <= reg_wdata; // RQ3 RQ14
    end
  end

  // prescaler; restarting the count on a start keeps the first edge a full period away
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt_reg <= 5'h00;
    end else if (start || div_val == 5'h00 || state_reg == ADCSC_ST_OFF) begin
      div_cnt_reg <= 5'h00;
    end else if (div_cnt_reg == div_val - 5'h01) begin
      div_cnt_reg <= 5'h00;
    end else begin
      div_cnt_reg <= div_cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= !start && div_val != 5'h00 && state_reg != ADCSC_ST_OFF
        && div_cnt_reg == div_val - 5'h01; // RQ15
    end
  end

  assign conv_clk_tick = tick_reg;

  // busy flag and the pending restart after halt or idle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      conversion_busy_flag <= 1'b0;
    end else if (start) begin
      conversion_busy_flag <= 1'b1; // RQ21
    end else if (stop_sw) begin
      conversion_busy_flag <= 1'b0; // RQ13
    end else if (complete && !adc_control_reg[ADCSC_CONT_BIT]) begin
      conversion_busy_flag <= 1'b0; // RQ21
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      restart_reg <= 1'b0;
    end else if (halt_idle && conversion_busy_flag && state_reg != ADCSC_ST_OFF) begin
      restart_reg <= 1'b1; // RQ19
    end else if (!halt_idle || stop_sw) begin
      restart_reg <= 1'b0;
    end
  end

  // sequencer
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ADCSC_ST_OFF; // RQ20
      phase_cnt_reg <= 4'h0;
    end else if (halt_idle || stop_sw) begin
      state_reg <= ADCSC_ST_OFF; // RQ19
      phase_cnt_reg <= 4'h0;
    end else if (start || restart_reg) begin
      state_reg <= ADCSC_ST_ARM; // RQ6 RQ19
      phase_cnt_reg <= 4'h0;
    end else if (tick_reg) begin
      unique case (state_reg)
        ADCSC_ST_OFF: begin
          phase_cnt_reg <= 4'h0;
        end
        ADCSC_ST_ARM: begin
          state_reg <= ADCSC_ST_SAMPLE; // RQ7 RQ17
          phase_cnt_reg <= ADCSC_SAMPLE_CYC;
        end
        ADCSC_ST_SAMPLE: begin
          if (phase_last) begin
            state_reg <= ADCSC_ST_CONVERT; // RQ17
            phase_cnt_reg <= ADCSC_CONVERT_CYC;
          end else begin
            phase_cnt_reg <= phase_cnt_reg - 4'h1;
          end
        end
        ADCSC_ST_CONVERT: begin
          if (phase_last) begin
            state_reg <= ADCSC_ST_LOAD; // RQ17
            phase_cnt_reg <= ADCSC_LOAD_CYC;
          end else begin
            phase_cnt_reg <= phase_cnt_reg - 4'h1;
          end
        end
        ADCSC_ST_LOAD: begin
          // a core that is late with its done keeps the load phase open
          if (complete && adc_control_reg[ADCSC_CONT_BIT]) begin
            state_reg <= ADCSC_ST_DESEL; // RQ10
            phase_cnt_reg <= ADCSC_DESEL_CYC;
          end else if (complete) begin
            state_reg <= ADCSC_ST_OFF; // RQ9
            phase_cnt_reg <= 4'h0;
          end
        end
        ADCSC_ST_DESEL: begin
          if (phase_last) begin
            state_reg <= ADCSC_ST_SAMPLE; // RQ10
            phase_cnt_reg <= ADCSC_SAMPLE_CYC;
          end else begin
            phase_cnt_reg <= phase_cnt_reg - 4'h1;
          end
        end
        // an illegal code parks the sequencer powered down
        default: begin
          state_reg <= ADCSC_ST_OFF;
          phase_cnt_reg <= 4'h0;
        end
      endcase
    end
  end

  // core result capture and transfer
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      data_hold_reg <= 8'h00;
    end else if (core_done) begin
      data_hold_reg <= core_data;
    end
  end

  // a done landing with the clear wins, so a late core answer is not lost
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      done_seen_reg <= 1'b0;
    end else if (core_done) begin
      done_seen_reg <= 1'b1;
    end else if (complete || state_reg == ADCSC_ST_ARM || state_reg == ADCSC_ST_OFF) begin
      done_seen_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      adc_result_reg <= ADCSC_RESULT_RST;
    end else if (complete) begin
      // load clock is dropping at this edge, so a read never sees a half value
      adc_result_reg <= data_hold_reg; // RQ11 RQ18
    end
  end

  // converter core controls, each phase output in its own flip-flop
  // select stays up from mid-sample to the end of load so the core keeps its input
  always_comb begin
    power_next = run_ok && (start || restart_reg
      || (state_reg != ADCSC_ST_OFF && !single_done));
    sample_next = run_ok && ((state_reg == ADCSC_ST_SAMPLE && !phase_last)
      || (tick_reg && (state_reg == ADCSC_ST_ARM
      || (state_reg == ADCSC_ST_DESEL && phase_last))));
    select_next = run_ok && ((state_reg == ADCSC_ST_SAMPLE && tick_reg
      && phase_cnt_reg == ADCSC_SAMPLE_CYC)
      || (select_reg && state_reg != ADCSC_ST_DESEL && !complete
      && state_reg != ADCSC_ST_ARM && state_reg != ADCSC_ST_OFF));
    load_next = run_ok && ((state_reg == ADCSC_ST_LOAD && !complete)
      || (state_reg == ADCSC_ST_CONVERT && phase_last));
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      power_up_reg <= 1'b0; // RQ20
    end else begin
      power_up_reg <= power_next; // RQ6 RQ9 RQ19
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sample_reg <= 1'b0;
    end else begin
      sample_reg <= sample_next; // RQ7
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      select_reg <= 1'b0;
    end else begin
      select_reg <= select_next; // RQ8 RQ10
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      load_clk_reg <= 1'b0;
    end else begin
      load_clk_reg <= load_next; // RQ11
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      diff_reg <= 1'b0;
    end else begin
      diff_reg <= adc_control_reg[ADCSC_DIFF_BIT]; // RQ3
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      vin_pos_reg <= 3'h0;
    end else begin
      vin_pos_reg <= chan; // RQ1
    end
  end

  // the partner code is kept even in single-ended mode, where the core ignores it
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      vin_neg_reg <= 3'h0;
    end else begin
      vin_neg_reg <= {chan[2:1], ~chan[0]}; // RQ2
    end
  end

  assign core_reg = '{power_up: power_up_reg, sample: sample_reg, select: select_reg,
    load_clk: load_clk_reg, diff: diff_reg, vin_pos: vin_pos_reg, vin_neg: vin_neg_reg};

  assign core_ctl = core_reg;

  // register reads, answered one cycle after the strobe
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADCSC_CTRL_OFF: reg_rdata <= adc_control_reg;
        ADCSC_RESULT_OFF: reg_rdata <= adc_result_reg;
        ADCSC_STATUS_OFF: reg_rdata <= {6'h00, core_reg.power_up, conversion_busy_flag};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

// File: testbench/adcsc_monitor.sv
// Purpose: port checker for the converter sequencer control
// Assumes: one clock, async active-low reset
// Notes: bound from the testbench top file
`timescale 1ns/1ns
module adcsc_monitor (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [adcsc_pkg::ADCSC_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic halt_idle,
  input adcsc_pkg::adcsc_core_s core_ctl,
  input wire logic conv_clk_tick
);
  import adcsc_pkg::*;
  logic ctl_wr;
  assign ctl_wr = reg_wr && reg_addr == ADCSC_CTRL_OFF;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_pre_off;
    !core_ctl.power_up && ctl_wr && reg_wdata[2:0] == 3'h0 |=> !core_ctl.power_up;
  endproperty
  a_pre_off: assert property (p_pre_off) else $error("powered with prescaler off");
  property p_start;
    !core_ctl.power_up && ctl_wr && reg_wdata[2:0] != 3'h0 && !halt_idle && !$past(halt_idle)
      |=> core_ctl.power_up;
  endproperty
  a_start: assert property (p_start) else $error("write did not power up");
  property p_fall_tick;
    $fell(core_ctl.sample) && !$past(halt_idle) && !$past(reg_wr) |-> $past(conv_clk_tick);
  endproperty
  a_fall_tick: assert property (p_fall_tick) else $error("sample ended off tick");
  property p_select_mid;
    $rose(core_ctl.select) |-> core_ctl.sample && $past(core_ctl.sample);
  endproperty
  a_select_mid: assert property (p_select_mid) else $error("select outside sample");
  property p_diff_pair;
    core_ctl.diff |-> core_ctl.vin_neg == (core_ctl.vin_pos ^ 3'h1);
  endproperty
  a_diff_pair: assert property (p_diff_pair) else $error("bad differential pair");
  property p_halt;
    halt_idle |=> !core_ctl.power_up;
  endproperty
  a_halt: assert property (p_halt) else $error("powered in halt");
  property p_quiet;
    !core_ctl.power_up |-> !core_ctl.sample && !core_ctl.select && !core_ctl.load_clk;
  endproperty
  a_quiet: assert property (p_quiet) else $error("phase active while off");
  property p_load_excl;
    core_ctl.load_clk |-> !core_ctl.sample && core_ctl.select;
  endproperty
  a_load_excl: assert property (p_load_excl) else $error("load overlaps sample");
endmodule

// File: testbench/adcsc_core_model.sv
// Purpose: behavioural converter core answering the load phase
// Assumes: load_clk high asks for a result
// Notes: slow delays the answer so the load phase is held open
`timescale 1ns/1ns
module adcsc_core_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input adcsc_pkg::adcsc_core_s core_ctl,
  input wire logic slow,
  output logic core_done,
  output logic [7:0] core_data
);
  import adcsc_pkg::*;
  logic [3:0] wait_reg;
  logic fire;
  assign fire = core_ctl.load_clk && wait_reg == (slow ? 4'h5 : 4'h0);
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wait_reg <= 4'h0;
      core_done <= 1'b0;
      core_data <= 8'h00;
    end else begin
      wait_reg <= core_ctl.load_clk ? wait_reg + 4'h1 : 4'h0;
      core_done <= fire;
      // data toggles outside done so a stray capture shows up
      core_data <= fire ? {core_ctl.vin_pos, core_ctl.diff, 4'ha} : ~core_data;
    end
  end
endmodule

// File: testbench/tb_adcsc_top.sv
// Purpose: register-level test of the converter sequencer control
// Assumes: core model result is {vin_pos, diff, 4'ha}
// Notes: status busy polled with a bounded loop
`timescale 1ns/1ns
module tb_adcsc_top;
  import adcsc_pkg::*;
  logic ref_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, halt_idle = 0, slow = 0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, core_data, rd_val, ctl;
  logic core_done, conv_clk_tick;
  adcsc_core_s core_ctl;
  int mismatches = 0, compares = 0, n, gap;
  always #20 ref_clk = ~ref_clk;
  adcsc_top dut (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .halt_idle(halt_idle), .core_done(core_done), .core_data(core_data),
    .core_ctl(core_ctl), .conv_clk_tick(conv_clk_tick));
  adcsc_core_model core (.ref_clk(ref_clk), .resetn(resetn), .core_ctl(core_ctl),
    .slow(slow), .core_done(core_done), .core_data(core_data));
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [1:0] a, logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [1:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  task automatic wait_idle;
    n = 0;
    do begin
      rd(ADCSC_STATUS_OFF);
      n++;
    end while (rd_val[ADCSC_BUSY_BIT] !== 1'b0 && n < 400);
    if (n >= 400) begin
      mismatches++;
      stop_test();
    end
  endtask
  // ref_clk cycles between two converter ticks
  task automatic tick_gap;
    for (n = 0; n < 40 && conv_clk_tick !== 1'b1; n++) @(posedge ref_clk) #1;
    @(posedge ref_clk) #1;
    for (gap = 1; gap < 40 && conv_clk_tick !== 1'b1; gap++) @(posedge ref_clk) #1;
  endtask
  function automatic logic [7:0] div_of(logic [2:0] c);
    case (c)
      3'h1: return 8'h01;
      3'h2: return 8'h02;
      3'h3: return 8'h04;
      3'h4: return 8'h06;
      3'h5: return 8'h0c;
      3'h6: return 8'h08;
      default: return 8'h10;
    endcase
  endfunction
  initial begin
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(ADCSC_CTRL_OFF);
    check("ctrl reset", 8'h00, rd_val);
    rd(ADCSC_STATUS_OFF);
    check("status reset", 8'h00, rd_val);
    for (int i = 0; i < 8; i++) begin
      ctl = {i[2:0], i[1], 1'b0, (i == 0) ? 3'h5 : i[2:0]};
      slow <= i[0];
      wr(ADCSC_CTRL_OFF, ctl);
      tick_gap();
      check("divide", div_of(ctl[2:0]), 8'(gap));
      rd(ADCSC_CTRL_OFF);
      check("ctrl", ctl, rd_val);
      wait_idle();
      rd(ADCSC_RESULT_OFF);
      check("result", {i[2:0], i[1], 4'ha}, rd_val);
      rd(ADCSC_STATUS_OFF);
      check("status done", 8'h00, rd_val);
    end
    wr(ADCSC_CTRL_OFF, 8'h19);
    repeat (60) @(posedge ref_clk);
    rd(ADCSC_STATUS_OFF);
    check("cont busy", 8'h03, rd_val);
    wr(ADCSC_CTRL_OFF, 8'he1);
    rd(ADCSC_CTRL_OFF);
    check("ctrl locked", 8'h19, rd_val);
    rd(ADCSC_RESULT_OFF);
    check("cont result", 8'h1a, rd_val);
    wr(ADCSC_STATUS_OFF, 8'h00);
    rd(ADCSC_STATUS_OFF);
    check("busy clr", 8'h00, {7'h0, rd_val[ADCSC_BUSY_BIT]});
    wr(ADCSC_CTRL_OFF, 8'h41);
    rd(ADCSC_CTRL_OFF);
    check("ctrl new", 8'h41, rd_val);
    wait_idle();
    wr(ADCSC_RESULT_OFF, 8'hff);
    rd(ADCSC_RESULT_OFF);
    check("result ro", 8'h4a, rd_val);
    rd(2'h3);
    check("unmapped", 8'h00, rd_val);
    wr(ADCSC_CTRL_OFF, 8'h20);
    rd(ADCSC_STATUS_OFF);
    check("pre off", 8'h00, rd_val);
    wr(ADCSC_CTRL_OFF, 8'hc7);
    repeat (30) @(posedge ref_clk);
    halt_idle <= 1'b1;
    rd(ADCSC_STATUS_OFF);
    check("halt power", 8'h00, {7'h0, rd_val[ADCSC_POWER_BIT]});
    halt_idle <= 1'b0;
    wait_idle();
    rd(ADCSC_RESULT_OFF);
    check("after halt", 8'hca, rd_val);
    stop_test();
  end
endmodule
bind adcsc_top adcsc_monitor mon (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .halt_idle(halt_idle), .core_ctl(core_ctl),
  .conv_clk_tick(conv_clk_tick));
